// ==== hw/noise_reducer_port.sv ====
// Stream port of the noise reducer: two buffered inputs aligned at frame start, one blended output.
// Assumes upstream sources hold offered beats and that gated masters feed it through a FIFO.
`timescale 1ns/1ns
module noise_reducer_port
#(
    parameter logic [2:0] STRENGTH = nr_stream_pkg::STRENGTH_DEF
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic curr_valid,
    output logic curr_ready,
    input nr_stream_pkg::beat_s curr_beat,
    input wire logic prev_valid,
    output logic prev_ready,
    input nr_stream_pkg::beat_s prev_beat,
    output logic out_valid,
    input wire logic out_ready,
    output nr_stream_pkg::beat_s out_beat
);
    import nr_stream_pkg::*;

    core_s r;
    core_s nxt;
    logic c_valid;
    logic c_pop;
    beat_s c_beat;
    logic p_valid;
    logic p_pop;
    beat_s p_beat;
    logic out_free;
    logic pair_ok;

    // Buffers in front of both inputs; only the buffer outputs are examined for alignment.
    stream_slot u_curr
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .in_valid(curr_valid),
        .in_ready(curr_ready),
        .in_beat(curr_beat),
        .out_valid(c_valid),
        .out_ready(c_pop),
        .out_beat(c_beat)
    );

    stream_slot u_prev
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .in_valid(prev_valid),
        .in_ready(prev_ready),
        .in_beat(prev_beat),
        .out_valid(p_valid),
        .out_ready(p_pop),
        .out_beat(p_beat)
    );

    assign out_valid = r.out_valid;
    assign out_beat = r.out_beat;
    assign out_free = !r.out_valid || out_ready;
    assign pair_ok = c_valid && p_valid && (c_beat.sof == p_beat.sof);

    // Alignment and processing; every change waits for the clock enable so a frozen cycle holds all state.
    always_comb
    begin
        nxt = r;
        c_pop = 1'b0;
        p_pop = 1'b0;
        if (clk_en)
        begin
            if (r.out_valid && out_ready)
            begin
                nxt.out_valid = 1'b0;
            end
            case (r.mode)
                ALIGN:
                begin
                    // A buffered frame start stays put, which drops that input's ready.
                    p_pop = p_valid && !p_beat.sof;
                    c_pop = c_valid && !c_beat.sof;
                    if (c_valid && c_beat.sof && p_valid && p_beat.sof)
                    begin
                        nxt.mode = RUN;
                    end
                end
                RUN:
                begin
                    if (c_valid && p_valid && !pair_ok)
                    begin
                        nxt.mode = ALIGN;
                    end
                    else if (pair_ok && out_free)
                    begin
                        c_pop = 1'b1;
                        p_pop = 1'b1;
                        nxt.out_valid = 1'b1;
                        // Only active pixels ever arrive here, so no blanking is forwarded.
                        nxt.out_beat.data[LUMA_LO+:PIX_W] = blend(c_beat.data[LUMA_LO+:PIX_W],
                            p_beat.data[LUMA_LO+:PIX_W], STRENGTH);
                        nxt.out_beat.data[CHROMA_LO+:PIX_W] = blend(c_beat.data[CHROMA_LO+:PIX_W],
                            p_beat.data[CHROMA_LO+:PIX_W], STRENGTH);
                        nxt.out_beat.sof = c_beat.sof;
                        nxt.out_beat.end_of_line = c_beat.end_of_line;
                    end
                end
                default:
                begin
                    nxt.mode = ALIGN;
                end
            endcase
        end
    end

    // Starting in alignment means the first frame is always matched before anything leaves.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r <= '0;
        end
        else
        begin
            r <= nxt;
        end
    end

    // Checks on the alignment and output behaviour.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    a_out_hold_stable: assert property (out_valid && !out_ready |=> out_valid && $stable(out_beat))
    else $error("Output beat changed before it was taken.");

    a_prev_sof_hold: assert property (r.mode == ALIGN && p_valid && p_beat.sof |-> !prev_ready)
    else $error("Previous input ready high while its frame start waits.");

    a_curr_drop_ready: assert property (r.mode == ALIGN && clk_en && c_valid && !c_beat.sof |-> curr_ready)
    else $error("Current input ready low while dropping beats.");

    a_align_no_output: assert property (r.mode == ALIGN && !out_valid |=> !out_valid)
    else $error("Output beat produced during alignment.");

    a_sof_carried: assert property (clk_en && r.mode == RUN && pair_ok && out_free
        |=> out_valid && out_beat.sof == $past(c_beat.sof))
    else $error("Frame start not carried to the output beat.");

    a_eol_carried: assert property (clk_en && r.mode == RUN && pair_ok && out_free
        |=> out_beat.end_of_line == $past(c_beat.end_of_line))
    else $error("Line end not carried to the output beat.");

    a_enable_freeze: assert property (!clk_en |=> $stable(r) && $stable(c_beat) && $stable(p_beat))
    else $error("State moved while the clock enable was low.");

    a_realign_start: assert property (clk_en && r.mode == RUN && c_valid && p_valid && !pair_ok
        |=> r.mode == ALIGN)
    else $error("Unmatched frame start did not restart alignment.");

    a_bypass_copy: assert property (STRENGTH == 3'h0 && clk_en && r.mode == RUN && pair_ok && out_free
        |=> out_beat.data == $past(c_beat.data))
    else $error("Zero strength did not pass the current pixel.");
endmodule

// ==== hw/nr_stream_pkg.sv ====
// Shared types, constants and the blend function for the noise reducer stream port.
// Assumes one clock, an asynchronous active-low reset and a global clock enable.
package nr_stream_pkg;
    localparam int PIX_W = 8;
    localparam int DATA_W = 16;
    localparam int LUMA_LO = 0;
    localparam int CHROMA_LO = 8;
    localparam int BLEND_SHIFT = 3;
    localparam int ACC_W = PIX_W + 4;
    localparam logic [3:0] BLEND_ONE = 4'h8;
    localparam logic [2:0] STRENGTH_DEF = 3'h4;
    // Answer codes a control port would use; this build has no such port.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_ERROR = 2'h2;
    // No strobes, write answers or read data exist without a control port.

    // One stream beat: pixel word, frame start and line end.
    typedef struct packed
    {
        logic [DATA_W-1:0] data;
        logic sof;
        logic end_of_line;
    } beat_s;

    typedef struct packed
    {
        logic full;
        beat_s beat;
    } slot_s;

    typedef enum logic [0:0] {ALIGN, RUN} mode_e;

    typedef struct packed
    {
        mode_e mode;
        logic out_valid;
        beat_s out_beat;
    } core_s;

    // Weighted mix of current and previous sample; weight zero passes the current sample.
    function automatic logic [PIX_W-1:0] blend(input logic [PIX_W-1:0] cur, input logic [PIX_W-1:0] prv,
        input logic [2:0] k);
        logic [ACC_W-1:0] acc;
        acc = ACC_W'(cur) * ACC_W'(BLEND_ONE - {1'b0, k}) + ACC_W'(prv) * ACC_W'(k);
        blend = acc[PIX_W+BLEND_SHIFT-1:BLEND_SHIFT];
    endfunction
endpackage

// ==== hw/stream_slot.sv ====
// One-beat input buffer for a video stream input.
// Assumes the reader pops only while the clock enable is high.
`timescale 1ns/1ns
module stream_slot
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input nr_stream_pkg::beat_s in_beat,
    output logic out_valid,
    input wire logic out_ready,
    output nr_stream_pkg::beat_s out_beat
);
    import nr_stream_pkg::*;

    slot_s r;
    slot_s nxt;

    // Ready only while enabled, so a beat offered in a frozen cycle is never half taken.
    assign in_ready = clk_en && (!r.full || out_ready);
    assign out_valid = r.full;
    assign out_beat = r.beat;

    // A beat is taken only on ready and valid together.
    always_comb
    begin
        nxt = r;
        if (clk_en)
        begin
            if (r.full && out_ready)
            begin
                nxt.full = 1'b0;
            end
            if (in_valid && in_ready)
            begin
                nxt.full = 1'b1;
                nxt.beat = in_beat;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r <= '0;
        end
        else
        begin
            r <= nxt;
        end
    end
endmodule

// ==== tb/stream_sink.sv ====
// Downstream sink model for the noise reducer output stream.
// Assumes beats move on rising ref_clk edges while clk_en is high.
`timescale 1ns/1ns
module stream_sink
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [1:0] pace,
    input wire logic out_valid,
    output logic out_ready,
    input nr_stream_pkg::beat_s out_beat
);
    import nr_stream_pkg::*;
    beat_s got[$];
    logic late_r;
    logic tog_r;
    // Pace 0 pre-asserts ready, 1 registers it after valid, 2 ties it to valid and stalls.
    assign out_ready = (pace == 2'h0) || (pace == 2'h1 && late_r) || (pace == 2'h2 && out_valid && tog_r);
    // Beats are logged only where valid, ready and the enable meet.
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            late_r <= 1'b0;
            tog_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (out_valid && out_ready)
                got.push_back(out_beat);
            late_r <= out_valid && !late_r;
            tog_r <= !tog_r;
        end
    end
endmodule

// ==== tb/test_noise_reducer_port.sv ====
// Self-checking bench for the noise reducer stream port.
// Assumes the sink model logs every output beat it accepts.
`timescale 1ns/1ns
module test_noise_reducer_port;
    import nr_stream_pkg::*;
    localparam logic [2:0] K = 3'h4;
    logic ref_clk, rst_b, clk_en, curr_valid, curr_ready, prev_valid, prev_ready, out_valid, out_ready;
    logic c_hit, p_hit;
    logic [1:0] pace;
    beat_s curr_beat, prev_beat, out_beat;
    beat_s cq[$], pq[$], eq[$];
    int mismatches, n_tests, stalls;
    noise_reducer_port #(.STRENGTH(K)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
        .curr_valid(curr_valid), .curr_ready(curr_ready), .curr_beat(curr_beat), .prev_valid(prev_valid),
        .prev_ready(prev_ready), .prev_beat(prev_beat), .out_valid(out_valid), .out_ready(out_ready),
        .out_beat(out_beat));
    stream_sink SINK (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .pace(pace),
        .out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat));
    // Free-running clock.
    always #5 ref_clk = ~ref_clk;
    // Handshakes are judged at the falling edge, where ready has settled.
    always @(negedge ref_clk)
    begin
        c_hit = curr_valid && curr_ready;
        p_hit = prev_valid && prev_ready;
        if (prev_valid && !prev_ready && clk_en)
            stalls++;
    end
    // Sources hold a beat until taken; idle lines toggle so stale data never matches.
    // The sources follow clk_en through ready, as a FIFO-fed master would.
    always @(posedge ref_clk)
    begin
        #1;
        if (c_hit || !curr_valid)
        begin
            curr_valid = cq.size() > 0;
            curr_beat = cq.size() > 0 ? cq.pop_front() : ~curr_beat;
        end
        if (p_hit || !prev_valid)
        begin
            prev_valid = pq.size() > 0;
            prev_beat = pq.size() > 0 ? pq.pop_front() : ~prev_beat;
        end
    end
    function automatic logic [7:0] mix(input logic [7:0] c, input logic [7:0] p);
        mix = 8'((12'(c) * (12'h8 - 12'(K)) + 12'(p) * 12'(K)) >> 3);
    endfunction
    function automatic beat_s mk(input logic [7:0] b, input int i, input int n);
        beat_s r;
        r.data = {b + 8'(i), b + 8'(3 * i)};
        r.sof = (i == 0);
        r.end_of_line = (i == n - 1);
        return r;
    endfunction
    task check(input string name, input beat_s e, input beat_s g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask
    task check_bit(input string name, input logic e, input logic g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %b seen %b", name, e, g);
        end
    endtask
    // Queues one line-frame on both inputs and the blended result it should give.
    task frame(input int n);
        beat_s c, p, e;
        for (int i = 0; i < n; i++)
        begin
            c = mk(8'h10, i, n);
            p = mk(8'h90, i, n);
            e = c;
            e.data = {mix(c.data[15:8], p.data[15:8]), mix(c.data[7:0], p.data[7:0])};
            cq.push_back(c);
            pq.push_back(p);
            eq.push_back(e);
        end
    endtask
    task drain();
        int w;
        w = 0;
        while (SINK.got.size() < eq.size() && w < 300)
        begin
            @(posedge ref_clk);
            w++;
        end
        while (eq.size() > 0)
            check("out_beat", eq.pop_front(), SINK.got.size() > 0 ? SINK.got.pop_front() : '0);
    endtask
    task t_aligned();
        pace = 2'h2;
        frame(3);
        drain();
    endtask
    // Current input starts mid-frame, so its leading beats must be dropped.
    task t_misaligned();
        pace = 2'h1;
        stalls = 0;
        cq.push_back(mk(8'h33, 1, 9));
        cq.push_back(mk(8'h35, 2, 9));
        cq.push_back(mk(8'h37, 3, 9));
        frame(2);
        drain();
        check_bit("prev_stall", 1'b1, stalls > 0);
    endtask
    task t_enable();
        beat_s hold;
        pace = 2'h0;
        frame(4);
        repeat (4) @(posedge ref_clk);
        #1;
        hold = out_beat;
        clk_en = 1'b0;
        repeat (4)
        begin
            @(posedge ref_clk);
            #2;
            check("frozen_beat", hold, out_beat);
            check_bit("frozen_valid", 1'b1, out_valid);
            check_bit("curr_ready", 1'b0, curr_ready);
        end
        clk_en = 1'b1;
        drain();
    endtask
    task end_of_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // A hang costs a mismatch and ends the run the normal way.
    initial
    begin
        #100000;
        mismatches++;
        end_of_test();
    end
    initial
    begin
        {ref_clk, rst_b, curr_valid, prev_valid, c_hit, p_hit, pace} = '0;
        clk_en = 1'b1;
        curr_beat = '0;
        prev_beat = '0;
        repeat (8) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        t_aligned();
        t_misaligned();
        t_enable();
        end_of_test();
    end
endmodule
